// ===== modem_regs_pkg.sv
// Purpose: shared constants of the modem register bank
// Assumes: 8-bit registers behind a 7-bit serial register address
// Notes:   offsets are register addresses on the serial host port
package modem_regs_pkg;

  localparam int          REG_AW              = 7;
  localparam int          REG_DW              = 8;

  // register addresses
  localparam logic [6:0]  ADDR_HOST_PTR       = 7'h0d;
  localparam logic [6:0]  ADDR_TX_START       = 7'h0e;
  localparam logic [6:0]  ADDR_RX_START       = 7'h0f;
  localparam logic [6:0]  ADDR_LAST_START     = 7'h10;
  localparam logic [6:0]  ADDR_IRQ_MASK       = 7'h11;
  localparam logic [6:0]  ADDR_IRQ_FLAGS      = 7'h12;
  localparam logic [6:0]  ADDR_PAYLOAD_LEN    = 7'h13;
  localparam logic [6:0]  ADDR_HDR_HIGH       = 7'h14;
  localparam logic [6:0]  ADDR_HDR_LOW        = 7'h15;
  localparam logic [6:0]  ADDR_PKT_HIGH       = 7'h16;
  localparam logic [6:0]  ADDR_PKT_LOW        = 7'h17;
  localparam logic [6:0]  ADDR_DEMOD_STATE    = 7'h18;
  localparam logic [6:0]  ADDR_PKT_QUALITY    = 7'h19;

  // values after reset
  localparam logic [7:0]  RST_HOST_PTR        = 8'h00;
  localparam logic [7:0]  RST_TX_START        = 8'h80;
  localparam logic [7:0]  RST_RX_START        = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK        = 8'h00;
  localparam logic [7:0]  RST_IRQ_FLAGS       = 8'h00;
  localparam logic [4:0]  RST_DEMOD_LIVE      = 5'h10;

  // flag bit positions, mask uses the same positions
  localparam int          BIT_RX_TIMEOUT      = 7;
  localparam int          BIT_RX_DONE         = 6;
  localparam int          BIT_CRC_ERROR       = 5;
  localparam int          BIT_HEADER_OK       = 4;
  localparam int          BIT_TX_DONE         = 3;
  localparam int          BIT_CAD_DONE        = 2;
  localparam int          BIT_HOP_CHANGE      = 1;
  localparam int          BIT_CAD_FOUND       = 0;

  // serial frame layout
  localparam int          CMD_WRITE_BIT       = 7;
  localparam logic [2:0]  LAST_BIT_OF_BYTE    = 3'h7;

endpackage

// ===== packet_modem_irq_status_bank.sv
// Purpose: status, interrupt and buffer pointer registers of the packet modem
// Assumes: serial host port mode 0, pins synchronous to I_CLK and slower than it
// Notes:   first byte is write bit plus 7-bit address, bursts auto-increment
//
// How it works
// RULE1 - transmit start pointer, read/write, resets 0x80
// RULE2 - receive start pointer, read/write, resets zero
// RULE3 - read-only start address of last packet
// RULE4 - mask bit one suppresses matching flag interrupt
// RULE5 - bit7 receive timeout, write clears
// RULE6 - bit6 reception complete, write clears
// RULE7 - bit5 payload check error, write clears
// RULE8 - bit4 valid header received, write clears
// RULE9 - bit3 transmit complete, write clears
// RULE10 - bit2 activity check done, write clears
// RULE11 - bit1 hop channel change due, write clears
// RULE12 - bit0 activity found, write clears
// RULE13 - read-only last payload byte count
// RULE14 - 16-bit valid header count since receive entry
// RULE15 - 16-bit valid packet count since receive entry
// RULE16 - both counts held zero in sleep
// RULE17 - status bits 7-5 give last code rate
// RULE18 - last packet quality, signed, quarter dB
// RULE19 - status bits 4-0 track live demodulator
// RULE20 - host buffer pointer, read/write, resets zero
// RULE21 - masked flag recorded but no interrupt
`timescale 1ns/100ps

module packet_modem_irq_status_bank (
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_SCK,
  input  wire logic       I_NSS_N,
  input  wire logic       I_MOSI,
  output logic            O_MISO,
  output logic            O_MISO_OE,
  input  wire logic [7:0] I_FLAG_EVENT,
  input  wire logic [7:0] I_RX_START_ADDR,
  input  wire logic [7:0] I_RX_LENGTH,
  input  wire logic [7:0] I_RX_QUALITY,
  input  wire logic [2:0] I_HEADER_CODE_RATE,
  input  wire logic [4:0] I_DEMOD_LIVE,
  input  wire logic       I_SLEEP,
  input  wire logic       I_RX_ENTRY,
  output logic [7:0]      O_TX_BUFFER_START,
  output logic [7:0]      O_RX_BUFFER_START,
  output logic [7:0]      O_HOST_BUFFER_POINTER,
  output logic            O_IRQ
);

  typedef enum logic {PH_CMD, PH_DATA} phase_e;

  phase_e      phase_ff;
  logic        sck_prev_ff;
  logic [2:0]  bit_cnt_ff;
  logic [6:0]  in_shift_ff;
  logic [7:0]  out_shift_ff;
  logic        write_ff;
  logic [6:0]  addr_ff;
  logic [7:0]  mask_ff;
  logic [7:0]  flags_ff;
  logic [7:0]  last_start_ff;
  logic [7:0]  payload_len_ff;
  logic [7:0]  quality_ff;
  logic [2:0]  code_rate_ff;
  logic [4:0]  demod_live_ff;
  logic [15:0] header_tally_ff;
  logic [15:0] packet_tally_ff;

  logic        sck_rise;
  logic        sck_fall;
  logic        byte_end;
  logic [7:0]  rx_byte;
  logic        wr_commit;
  logic [6:0]  nxt_addr;
  logic        packet_ok;
  logic        tally_clear;
  logic [7:0]  rd_next;

  ////////////////////////////////////////////////////////////////////////////
  // serial host port

  // a bit is taken in the cycle where a rising sck is first seen with select
  // low; sck must stay low and high one clock each, since nothing here
  // filters or resynchronises the pins and a shorter pulse would be missed
  // edges found against the previous sample; pins are already in this domain
  assign sck_rise  = I_SCK & ~sck_prev_ff & ~I_NSS_N;
  assign sck_fall  = ~I_SCK & sck_prev_ff & ~I_NSS_N;
  assign byte_end  = sck_rise & (bit_cnt_ff == modem_regs_pkg::LAST_BIT_OF_BYTE);
  assign rx_byte   = {in_shift_ff, I_MOSI};
  assign wr_commit = byte_end & (phase_ff == PH_DATA) & write_ff;
  // address taken from the command byte, then stepped after every data byte
  assign nxt_addr  = (phase_ff == PH_CMD) ? rx_byte[6:0] : addr_ff + 7'h01;

  // read view of the bank, unmapped addresses read zero
  function automatic logic [7:0] rd_data(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      modem_regs_pkg::ADDR_HOST_PTR:    v = O_HOST_BUFFER_POINTER;
      modem_regs_pkg::ADDR_TX_START:    v = O_TX_BUFFER_START;
      modem_regs_pkg::ADDR_RX_START:    v = O_RX_BUFFER_START;
      modem_regs_pkg::ADDR_LAST_START:  v = last_start_ff;
      modem_regs_pkg::ADDR_IRQ_MASK:    v = mask_ff;
      modem_regs_pkg::ADDR_IRQ_FLAGS:   v = flags_ff;
      modem_regs_pkg::ADDR_PAYLOAD_LEN: v = payload_len_ff;
      modem_regs_pkg::ADDR_HDR_HIGH:    v = header_tally_ff[15:8];
      modem_regs_pkg::ADDR_HDR_LOW:     v = header_tally_ff[7:0];
      modem_regs_pkg::ADDR_PKT_HIGH:    v = packet_tally_ff[15:8];
      modem_regs_pkg::ADDR_PKT_LOW:     v = packet_tally_ff[7:0];
      modem_regs_pkg::ADDR_DEMOD_STATE: v = {code_rate_ff, demod_live_ff};
      modem_regs_pkg::ADDR_PKT_QUALITY: v = quality_ff;
      default:                          v = 8'h00;
    endcase
    return v;
  endfunction

  // next read byte; a process and not an assign, so that it also follows
  // the registers that the function reads, not only the address
  always_comb begin
    rd_next = rd_data(nxt_addr);
  end

  // frame sequencing: nss high aborts any partial byte
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sck_prev_ff <= 1'b0;
      bit_cnt_ff  <= 3'h0;
      in_shift_ff <= 7'h00;
      phase_ff    <= PH_CMD;
      write_ff    <= 1'b0;
      addr_ff     <= 7'h00;
    end else begin
      sck_prev_ff <= I_SCK;
      if (I_NSS_N) begin
        bit_cnt_ff <= 3'h0;
        phase_ff   <= PH_CMD;
      end else if (sck_rise) begin
        bit_cnt_ff  <= bit_cnt_ff + 3'h1;
        in_shift_ff <= rx_byte[6:0];
        if (byte_end) begin
          addr_ff  <= nxt_addr;
          phase_ff <= PH_DATA;
          if (phase_ff == PH_CMD) begin
            write_ff <= rx_byte[modem_regs_pkg::CMD_WRITE_BIT];
          end
        end
      end
    end
  end

  // read data: loaded at byte end, shifted out on falling edges, msb first
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      out_shift_ff <= 8'h00;
      O_MISO       <= 1'b0;
      O_MISO_OE    <= 1'b0;
    end else begin
      O_MISO_OE <= ~I_NSS_N;
      if (I_NSS_N) begin
        O_MISO <= 1'b0;
      end else if (byte_end) begin
        // a write burst also loads, harmless and keeps the path simple
        out_shift_ff <= rd_next;
        O_MISO       <= rd_next[7];
      end else if (sck_fall && bit_cnt_ff != 3'h0) begin
        O_MISO       <= out_shift_ff[6];
        out_shift_ff <= {out_shift_ff[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host written registers

  // writes land on the edge of the last data bit; read-only places fall through
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_HOST_BUFFER_POINTER <= modem_regs_pkg::RST_HOST_PTR;
      O_TX_BUFFER_START     <= modem_regs_pkg::RST_TX_START;
      O_RX_BUFFER_START     <= modem_regs_pkg::RST_RX_START;
      mask_ff               <= modem_regs_pkg::RST_IRQ_MASK;
    end else if (wr_commit) begin
      if (addr_ff == modem_regs_pkg::ADDR_HOST_PTR) begin
        O_HOST_BUFFER_POINTER <= rx_byte; // RULE20
      end
      if (addr_ff == modem_regs_pkg::ADDR_TX_START) begin
        O_TX_BUFFER_START <= rx_byte; // RULE1
      end
      if (addr_ff == modem_regs_pkg::ADDR_RX_START) begin
        O_RX_BUFFER_START <= rx_byte; // RULE2
      end
      if (addr_ff == modem_regs_pkg::ADDR_IRQ_MASK) begin
        mask_ff <= rx_byte; // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags and output

  // write one to clear; an event in the same cycle wins over the clear
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      flags_ff <= modem_regs_pkg::RST_IRQ_FLAGS;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (I_FLAG_EVENT[i]) begin
          flags_ff[i] <= 1'b1; // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
        end else if (wr_commit && addr_ff == modem_regs_pkg::ADDR_IRQ_FLAGS && rx_byte[i]) begin
          flags_ff[i] <= 1'b0;
        end
      end
    end
  end

  // masked flags stay recorded, they only stay off the pin
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(flags_ff & ~mask_ff); // RULE4 RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive results and counters

  // packet data captured as reception completes
  // no value is defined before the first packet, so these start at zero
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      last_start_ff  <= 8'h00;
      payload_len_ff <= 8'h00;
      quality_ff     <= 8'h00;
    end else if (I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE]) begin
      last_start_ff  <= I_RX_START_ADDR; // RULE3
      payload_len_ff <= I_RX_LENGTH; // RULE13
      quality_ff     <= I_RX_QUALITY; // RULE18
    end
  end

  // code rate follows headers, live bits sampled every cycle
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      code_rate_ff  <= 3'h0;
      demod_live_ff <= modem_regs_pkg::RST_DEMOD_LIVE;
    end else begin
      demod_live_ff <= I_DEMOD_LIVE; // RULE19
      if (I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK]) begin
        code_rate_ff <= I_HEADER_CODE_RATE; // RULE17
      end
    end
  end

  // a packet is valid only when its completion carries no check error
  assign packet_ok   = I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE] &
                       ~I_FLAG_EVENT[modem_regs_pkg::BIT_CRC_ERROR];
  assign tally_clear = I_SLEEP | I_RX_ENTRY;

  // counters wrap at 16 bits; sleep or a new receive entry restarts them
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      header_tally_ff <= 16'h0000;
      packet_tally_ff <= 16'h0000;
    end else if (tally_clear) begin
      header_tally_ff <= 16'h0000; // RULE16
      packet_tally_ff <= 16'h0000; // RULE16
    end else begin
      if (I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK]) begin
        header_tally_ff <= header_tally_ff + 16'h0001; // RULE14
      end
      if (packet_ok) begin
        packet_tally_ff <= packet_tally_ff + 16'h0001; // RULE15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [7:0] flag_clr;
  assign flag_clr = (wr_commit && addr_ff == modem_regs_pkg::ADDR_IRQ_FLAGS) ? rx_byte : 8'h00;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_tx_start_write: assert property ( // RULE1
    wr_commit && addr_ff == modem_regs_pkg::ADDR_TX_START |=> O_TX_BUFFER_START == $past(rx_byte))
    else $error("tx start pointer missed a write");
  chk_rx_start_write: assert property ( // RULE2
    wr_commit && addr_ff == modem_regs_pkg::ADDR_RX_START |=> O_RX_BUFFER_START == $past(rx_byte))
    else $error("rx start pointer missed a write");
  chk_ptr_write: assert property ( // RULE20
    wr_commit && addr_ff == modem_regs_pkg::ADDR_HOST_PTR
      |=> O_HOST_BUFFER_POINTER == $past(rx_byte))
    else $error("host pointer missed a write");
  chk_last_start: assert property ( // RULE3
    I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE] |=> last_start_ff == $past(I_RX_START_ADDR))
    else $error("last packet start not captured");
  chk_length_capture: assert property ( // RULE13
    I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE] |=> payload_len_ff == $past(I_RX_LENGTH))
    else $error("payload length not captured");
  chk_quality_capture: assert property ( // RULE18
    I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE] |=> quality_ff == $past(I_RX_QUALITY))
    else $error("packet quality not captured");
  chk_flag_sets: assert property ( // RULE6
    I_FLAG_EVENT != 8'h00 |=> (flags_ff & $past(I_FLAG_EVENT)) == $past(I_FLAG_EVENT))
    else $error("event did not set its flag");
  chk_flag_clears: assert property ( // RULE5
    flag_clr != 8'h00 |=> flags_ff == (($past(flags_ff) & ~$past(flag_clr)) | $past(I_FLAG_EVENT)))
    else $error("flag clear wrong");
  chk_irq_masked: assert property ( // RULE21
    (flags_ff & ~mask_ff) == 8'h00 |=> !O_IRQ)
    else $error("interrupt raised by masked flag");
  chk_irq_raised: assert property ( // RULE4
    (flags_ff & ~mask_ff) != 8'h00 |=> O_IRQ)
    else $error("unmasked flag gave no interrupt");
  chk_header_count: assert property ( // RULE14
    I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK] && !tally_clear
      |=> header_tally_ff == $past(header_tally_ff) + 16'h0001)
    else $error("header count did not step");
  chk_packet_count: assert property ( // RULE15
    packet_ok && !tally_clear |=> packet_tally_ff == $past(packet_tally_ff) + 16'h0001)
    else $error("packet count did not step");
  chk_sleep_zero: assert property ( // RULE16
    I_SLEEP [*2] |-> header_tally_ff == 16'h0000 && packet_tally_ff == 16'h0000)
    else $error("counts not zero in sleep");
  chk_code_rate: assert property ( // RULE17
    I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK] |=> code_rate_ff == $past(I_HEADER_CODE_RATE))
    else $error("code rate not captured");
  chk_live_track: assert property ( // RULE19
    ##1 demod_live_ff == $past(I_DEMOD_LIVE))
    else $error("live status not tracking");


  // hold checks, with mask write, entry clear and idle miso: a register moves only by its own write or event
  chk_tx_start_hold: assert property ( // RULE1
    !(wr_commit && addr_ff == modem_regs_pkg::ADDR_TX_START) |=> $stable(O_TX_BUFFER_START))
    else $error("tx start pointer changed without a write");
  chk_rx_start_hold: assert property ( // RULE2
    !(wr_commit && addr_ff == modem_regs_pkg::ADDR_RX_START) |=> $stable(O_RX_BUFFER_START))
    else $error("rx start pointer changed without a write");
  chk_mask_write: assert property ( // RULE4
    wr_commit && addr_ff == modem_regs_pkg::ADDR_IRQ_MASK |=> mask_ff == $past(rx_byte))
    else $error("mask missed a write");
  chk_flag_hold: assert property ( // RULE7
    I_FLAG_EVENT == 8'h00 && flag_clr == 8'h00 |=> $stable(flags_ff))
    else $error("flags changed without an event or a clear");
  chk_last_hold: assert property ( // RULE13
    !I_FLAG_EVENT[modem_regs_pkg::BIT_RX_DONE]
      |=> $stable(payload_len_ff) && $stable(last_start_ff) && $stable(quality_ff))
    else $error("packet facts changed without a reception");
  chk_entry_zero: assert property ( // RULE14
    I_RX_ENTRY |=> header_tally_ff == 16'h0000 && packet_tally_ff == 16'h0000)
    else $error("counts not zero after receive entry");
  chk_header_hold: assert property ( // RULE14
    !I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK] && !tally_clear
      |=> $stable(header_tally_ff))
    else $error("header count moved without a header");
  chk_packet_hold: assert property ( // RULE15
    !packet_ok && !tally_clear |=> $stable(packet_tally_ff))
    else $error("packet count moved without a clean packet");
  chk_code_rate_hold: assert property ( // RULE17
    !I_FLAG_EVENT[modem_regs_pkg::BIT_HEADER_OK] |=> $stable(code_rate_ff))
    else $error("code rate changed without a header");
  chk_miso_idle: assert property ( // RULE20
    I_NSS_N |=> !O_MISO && !O_MISO_OE)
    else $error("serial output active while deselected");

  cov_write_burst: cover property (wr_commit ##[1:40] wr_commit);
  cov_flag_clear: cover property (flag_clr != 8'h00);
  cov_irq_rise: cover property (!O_IRQ ##1 O_IRQ);
  cov_read_frame: cover property (byte_end && phase_ff == PH_DATA && !write_ff);
  cov_sleep_clear: cover property (I_SLEEP && header_tally_ff != 16'h0000);

endmodule

// ===== modem_host_model.sv
// Purpose: host controller model driving the serial register port
// Assumes: mode 0, sck low and high two clock cycles each, pins moved on falling clock
// Notes:   a released miso line reads as the inverse of the last bit seen
`timescale 1ns/100ps

module modem_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  output logic      o_sck,
  output logic      o_nss_n,
  output logic      o_mosi
);
  logic last_bit;

  initial begin
    o_sck    = 1'b0;
    o_nss_n  = 1'b1;
    o_mosi   = 1'b0;
    last_bit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one byte each way, msb first; miso sampled just before each rise
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_mosi = tx[b];
      repeat (2) @(negedge i_clk);
      rx[b]    = i_miso_oe ? i_miso : ~last_bit;
      last_bit = rx[b];
      o_sck    = 1'b1;
      repeat (2) @(negedge i_clk);
      o_sck = 1'b0;
    end
  endtask

  // select low, then command byte with write bit and address
  task automatic open_frame(input logic wr, input logic [6:0] a);
    logic [7:0] junk;
    o_nss_n = 1'b0;
    @(negedge i_clk);
    xfer_byte({wr, a}, junk);
  endtask

  // deselect and leave a gap before the next frame
  task automatic close_frame();
    @(negedge i_clk);
    o_nss_n = 1'b1;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    open_frame(1'b1, a);
    xfer_byte(d, junk);
    close_frame();
  endtask

  // burst of four reads, first address in the top byte
  task automatic reg_rd4(input logic [6:0] a, output logic [31:0] d);
    open_frame(1'b0, a);
    for (int k = 3; k >= 0; k--) begin
      xfer_byte(8'hff, d[k*8 +: 8]);
    end
    close_frame();
  endtask
endmodule

// ===== packet_modem_irq_status_bank_test.sv
// Purpose: self-checking bench for the modem status and interrupt registers
// Assumes: host model owns the serial pins, bench owns the modem event inputs
// Notes:   event inputs move on the falling clock edge
`timescale 1ns/100ps

module packet_modem_irq_status_bank_test;
  logic        clk, resetn, sck, nss_n, mosi, miso, miso_oe, sleep, rx_entry, irq;
  logic [7:0]  flag_event, rx_addr, rx_len, rx_qual, tx_start, rx_start, host_ptr;
  logic [2:0]  code_rate;
  logic [4:0]  live;
  logic [31:0] rd;
  int          err_count, compares;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  packet_modem_irq_status_bank packet_modem_irq_status_bank_i (
    .I_CLK(clk), .I_RESETN(resetn), .I_SCK(sck), .I_NSS_N(nss_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE(miso_oe), .I_FLAG_EVENT(flag_event),
    .I_RX_START_ADDR(rx_addr), .I_RX_LENGTH(rx_len), .I_RX_QUALITY(rx_qual),
    .I_HEADER_CODE_RATE(code_rate), .I_DEMOD_LIVE(live), .I_SLEEP(sleep),
    .I_RX_ENTRY(rx_entry), .O_TX_BUFFER_START(tx_start), .O_RX_BUFFER_START(rx_start),
    .O_HOST_BUFFER_POINTER(host_ptr), .O_IRQ(irq));

  modem_host_model modem_host_model_i (
    .i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_sck(sck), .o_nss_n(nss_n), .o_mosi(mosi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one cycle event pulse; flag lands on the next edge
  task automatic pulse(input logic [7:0] ev);
    @(negedge clk);
    flag_event = ev;
    @(negedge clk);
    flag_event = 8'h00;
  endtask

  task automatic wrap_up();
    $display("counts: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset values through the ports and the serial port
  task automatic t_reset();
    chk({tx_start, rx_start, host_ptr, 7'h00, irq}, 32'h80000000);
    modem_host_model_i.reg_rd4(7'h0e, rd);
    chk({rd[31:24], rd[23:16], rd[15:0] & 16'hff00}, 32'h80000000);
    modem_host_model_i.reg_rd4(7'h11, rd);
    chk(rd[31:16], 32'h0000);
    modem_host_model_i.reg_rd4(7'h18, rd);
    chk(rd[31:24], 32'h10);
    $display("test reset done");
  endtask

  // burst write across three pointers, then read-only and unmapped places
  task automatic t_pointers();
    logic [7:0] junk;
    modem_host_model_i.open_frame(1'b1, 7'h0d);
    modem_host_model_i.xfer_byte(8'h3c, junk);
    modem_host_model_i.xfer_byte(8'h5a, junk);
    modem_host_model_i.xfer_byte(8'ha5, junk);
    modem_host_model_i.close_frame();
    chk({host_ptr, tx_start, rx_start}, 32'h3c5aa5);
    modem_host_model_i.reg_rd4(7'h0d, rd);
    chk(rd[31:8], 32'h3c5aa5);
    modem_host_model_i.reg_wr(7'h10, 8'h77);
    modem_host_model_i.reg_rd4(7'h10, rd);
    chk(rd[31:24], 32'h00);
    modem_host_model_i.reg_rd4(7'h05, rd);
    chk(rd[31:24], 32'h00);
    $display("test pointers done");
  endtask

  // every flag raised alone, write of zero keeps it, write of one clears
  task automatic t_flags();
    logic [7:0] ev;
    for (int i = 0; i < 8; i++) begin
      ev = 8'h01 << i;
      pulse(ev);
      @(negedge clk);
      chk(irq, 1'b1);
      modem_host_model_i.reg_wr(7'h12, ~ev);
      modem_host_model_i.reg_rd4(7'h12, rd);
      chk(rd[31:24], ev);
      modem_host_model_i.reg_wr(7'h12, ev);
      modem_host_model_i.reg_rd4(7'h12, rd);
      chk({rd[31:24], 7'h00, irq}, 32'h0000);
    end
    $display("test flags done");
  endtask

  // masked flags still recorded, interrupt follows mask release
  task automatic t_mask();
    modem_host_model_i.reg_wr(7'h11, 8'hff);
    pulse(8'hff);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    modem_host_model_i.reg_rd4(7'h11, rd);
    chk(rd[31:16], 32'hffff);
    modem_host_model_i.reg_wr(7'h11, 8'hfe);
    chk(irq, 1'b1);
    modem_host_model_i.reg_wr(7'h12, 8'h01);
    chk(irq, 1'b0);
    modem_host_model_i.reg_wr(7'h12, 8'hff);
    modem_host_model_i.reg_wr(7'h11, 8'h00);
    $display("test mask done");
  endtask

  // captured packet facts, counters, crc failure, receive entry and sleep
  task automatic t_capture();
    rx_addr   = 8'h40;
    rx_len    = 8'h21;
    rx_qual   = 8'hf6;
    code_rate = 3'h5;
    live      = 5'h0b;
    rx_entry  = 1'b1;
    @(negedge clk);
    rx_entry  = 1'b0;
    pulse(8'h10);
    pulse(8'h40);
    pulse(8'h60);
    modem_host_model_i.reg_rd4(7'h10, rd);
    chk(rd, 32'h40007021);
    modem_host_model_i.reg_rd4(7'h14, rd);
    chk(rd, 32'h00010001);
    modem_host_model_i.reg_rd4(7'h16, rd);
    chk(rd[31:8], 32'h0001ab);
    chk(rd[7:0], 32'hf6);
    pulse(8'h10);
    @(negedge clk);
    rx_entry = 1'b1;
    @(negedge clk);
    rx_entry = 1'b0;
    pulse(8'h50);
    sleep = 1'b1;
    pulse(8'h50);
    modem_host_model_i.reg_rd4(7'h14, rd);
    chk(rd, 32'h00000000);
    sleep = 1'b0;
    pulse(8'h10);
    modem_host_model_i.reg_rd4(7'h14, rd);
    chk(rd, 32'h00010000);
    $display("test capture done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the serial waits are fixed, this cuts any other hang
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    {resetn, sleep, rx_entry, flag_event} = '0;
    {rx_addr, rx_len, rx_qual, code_rate} = '0;
    live = 5'h10;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_reset();
    t_pointers();
    t_flags();
    t_mask();
    t_capture();
    wrap_up();
  end
endmodule
